/* pmc_checker_assertions.sv */
// port-level checks of idle, power-down and wake behaviour
`timescale 1ns/10ps
`default_nettype none
module pmc_checker_assertions
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_b,
  // watched ports
  input wire logic       cpu_cycle_en,
  input wire logic       core_reset,
  input wire logic       addr_latch_strobe,
  input wire logic       program_fetch_strobe,
  input wire logic       port_hold,
  input wire logic       port_from_regs,
  input wire logic       osc_run,
  input wire logic       periph_tick,
  input wire logic       irq_pending,
  input wire logic [1:0] ext_int_b,
  input wire logic [1:0] ext_int_en,
  input wire logic       global_irq_enable,
  input wire logic       wdt_irq,
  input wire logic       ext_rst_pin
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // ====
  // idle
  a_idle_strobes_high: assert property (port_hold |-> addr_latch_strobe && program_fetch_strobe)
    else $error("idle strobes low");
  a_idle_core_halt: assert property (port_hold |-> !cpu_cycle_en)
    else $error("core runs in idle");
  // a reset ends idle and hands the tick to the core cycle counter, so it excuses an early tick
  a_idle_periph_rate: assert property (port_hold && periph_tick && !core_reset |=>
    (!periph_tick || core_reset) [*3] ##1 (periph_tick || !port_hold || core_reset))
    else $error("idle tick rate");
  a_idle_irq_wake: assert property (port_hold && irq_pending |=> !port_hold)
    else $error("irq kept idle");
  a_wdt_idle_wake: assert property (port_hold && wdt_irq |=> !port_hold)
    else $error("watchdog kept idle");
  // ====
  // power-down
  a_pd_strobes_low: assert property (port_from_regs |-> !addr_latch_strobe && !program_fetch_strobe)
    else $error("pd strobes high");
  a_pd_clocks_stop: assert property (port_from_regs |-> !osc_run && !cpu_cycle_en && !periph_tick)
    else $error("clocks run in pd");
  a_pd_pin_wake: assert property (port_from_regs && global_irq_enable &&
    ((ext_int_en & ~ext_int_b) != 2'h0) |-> ##[1:3] !port_from_regs)
    else $error("pin kept pd");
  a_pd_rst_wake: assert property (port_from_regs && ext_rst_pin |=> core_reset)
    else $error("no reset in pd");
  c_idle_entry: cover property ($rose(port_hold));
  c_pd_entry: cover property ($rose(port_from_regs));
  c_wdt_reset: cover property ($rose(wdt_irq) ##[1:600] $rose(core_reset));
endmodule : pmc_checker_assertions
bind pmc_power_mode_clock_manager pmc_checker_assertions i_chk
(
  .sys_clk, .rst_b, .cpu_cycle_en, .core_reset, .addr_latch_strobe, .program_fetch_strobe,
  .port_hold, .port_from_regs, .osc_run, .periph_tick, .irq_pending, .ext_int_b, .ext_int_en,
  .global_irq_enable, .wdt_irq, .ext_rst_pin
);
`default_nettype wire

/* pmc_core_model.sv */
// processor core stand-in: one-cycle instructions and toggling bus strobes
`timescale 1ns/10ps
`default_nettype none
module pmc_core_model
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // manager side
  input  wire logic cpu_cycle_en,
  input  wire logic core_reset,
  output logic      instr_done,
  output logic      ale_core,
  output logic      program_fetch_strobe_core
);
  logic [31:0] instr_cnt_q;
  // ====
  // instruction stream
  // no cycle enable means no instruction, so a frozen core retires nothing
  assign instr_done = cpu_cycle_en && !core_reset;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      instr_cnt_q <= 32'h0;
    else if (instr_done)
      instr_cnt_q <= instr_cnt_q + 32'h1;
  end
  // ====
  // bus strobes, parked while in reset
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b || core_reset)
    begin
      ale_core                  <= 1'b0;
      program_fetch_strobe_core <= 1'b1;
    end
    else if (instr_done)
    begin
      ale_core                  <= !ale_core;
      program_fetch_strobe_core <= ale_core;
    end
  end
endmodule : pmc_core_model
`default_nettype wire

/* pmc_cycle_gen.sv */
// machine cycle generator: core and peripheral tick pulses
`timescale 1ns/10ps
`default_nettype none
`include "pmc_regs.svh"
module pmc_cycle_gen
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // tick carrier
  pmc_tick_if.gen  tk
);
  import pmc_pkg::*;

  function automatic logic [10:0] clks_per_cycle(input pmc_div_t d);
    case (d)
      `PMC_DIV_SLOW:    clks_per_cycle = `PMC_CLKS_DIV64;
      `PMC_DIV_SLOWEST: clks_per_cycle = `PMC_CLKS_DIV1024;
      default:          clks_per_cycle = `PMC_CLKS_DIV4;
    endcase
  endfunction : clks_per_cycle

  logic [10:0] cnt_q;
  logic [1:0]  pcnt_q;
  logic        wrap;

  // >= so a switchback to a shorter cycle never waits out the long count
  assign wrap = cnt_q >= (clks_per_cycle(tk.div_sel) - 11'h001);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_q <= 11'h000;
    else if (tk.pdown || wrap)
      cnt_q <= 11'h000;
    else
      cnt_q <= cnt_q + 11'h001;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pcnt_q <= 2'h0;
    else if (tk.pdown)
      pcnt_q <= 2'h0;
    else
      pcnt_q <= pcnt_q + 2'h1;
  end

  assign tk.core_tick   = !tk.pdown && wrap;
  assign tk.periph_tick = tk.idle ? (!tk.pdown && pcnt_q == 2'h3) : tk.core_tick;
endmodule : pmc_cycle_gen
`default_nettype wire

/* pmc_pkg.sv */
// types shared by the power mode clock manager files
package pmc_pkg;
  typedef enum logic [2:0]
  {
    PMC_RUN   = 3'b001,
    PMC_IDLE  = 3'b010,
    PMC_PDOWN = 3'b100
  } pmc_state_e;
  typedef logic [1:0] pmc_div_t;
  typedef logic [7:0] pmc_byte_t;
endpackage : pmc_pkg

/* pmc_power_mode_clock_manager.sv */
// power mode clock manager: idle, economy and power-down control
//
// Functional notes
// - idle request takes effect once the requesting instruction completes
// - idle gates the core clock; interrupt, timer, watchdog, serial keep ticking
// - idle holds both bus strobes high and freezes port levels
// - enabled interrupt in idle clears idle bit and resumes execution
// - reset pin high two machine cycles is a reset; restart at zero
// - watchdog runs in idle, wakes it, resets 512 clocks later if unserviced
// - reset out of idle discards the instruction after the idle request
// - divide select: 00 reserved, 01 four, 10 sixty-four, 11 1024 clocks
// - economy slows peripherals with core; idle keeps them at clock/4
// - new divide selection applies two instruction cycles after the write
// - switchback on serial activity or external interrupt acknowledge restores divide-by-4
// - switchback triggers: receive start falling edge, any transmit buffer write
// - switchback ignores serial interrupt flags
// - divide writes dropped during serial activity while switchback enabled
// - every reset source restores divide-by-4
// - power-down stops all clocks; strobes low; ports show register values
// - reset pin ends power-down and restarts at zero; watchdog cannot
// - enabled external interrupt low level wakes power-down with global enable
// - reset source flags record power-on and watchdog resets
`timescale 1ns/10ps
`default_nettype none
`include "pmc_regs.svh"
module pmc_power_mode_clock_manager
#(
  parameter int unsigned WDT_PERIOD = 131072
)
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // register port
  input  wire pmc_pkg::pmc_byte_t reg_addr,
  input  wire pmc_pkg::pmc_byte_t reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output var  pmc_pkg::pmc_byte_t reg_rdata,
  // core side
  input  wire logic             instr_done,
  input  wire logic             ale_core,
  input  wire logic             program_fetch_strobe_core,
  output logic                  cpu_cycle_en,
  output logic                  core_reset,
  output logic                  addr_latch_strobe,
  output logic                  program_fetch_strobe,
  output logic                  port_hold,
  output logic                  port_from_regs,
  output logic                  osc_run,
  output logic                  periph_tick,
  // interrupt side
  input  wire logic             irq_pending,
  input  wire logic [1:0]       ext_int_b,
  input  wire logic [1:0]       ext_int_en,
  input  wire logic             global_irq_enable,
  input  wire logic             ext_irq_ack,
  output logic                  wdt_irq,
  // serial side
  input  wire logic             ser_rx_pin,
  input  wire logic             ser_rx_enable,
  input  wire logic             ser_tx_write,
  input  wire logic             ser_busy,
  // reset sources
  input  wire logic             ext_rst_pin,
  input  wire logic             power_fail
);
  import pmc_pkg::*;

  // ====
  // declarations
  pmc_tick_if tk ();

  pmc_state_e state_q;
  pmc_state_e state_d;
  logic       idle_q;
  logic       pd_q;
  logic       swb_q;
  pmc_div_t   div_q;
  pmc_div_t   pend_div_q;
  logic       pend_q;
  logic [1:0] settle_q;
  logic       rst_en_q;
  logic [16:0] wdt_cnt_q;
  logic       armed_q;
  logic [9:0] rcnt_q;
  logic       wdto_q;
  logic       por_q;
  logic       wdrst_q;
  logic       rx_prev_q;
  logic       ale_q;
  logic       program_fetch_strobe_q;
  logic       hold_q;
  logic       regs_q;
  logic       wr_power_control_reg;
  logic       wr_pmr;
  logic       wr_wdt;
  logic       wr_stat;
  logic       restart;
  logic       sb_evt;
  logic       wdt_fire;
  logic       wdt_expire;
  logic       wake_idle;
  logic       wake_pd;
  logic       idle_req;
  logic       pd_req;
  logic       sys_rst;

  function automatic logic hit(input pmc_byte_t a, input pmc_byte_t off);
    hit = (a == off);
  endfunction : hit

  // ====
  // leaves
  pmc_cycle_gen u_gen
  (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .tk      (tk.gen)
  );

  pmc_reset_seq u_seq
  (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .tk      (tk.seq)
  );

  assign tk.div_sel = div_q;
  assign tk.idle    = (state_q == PMC_IDLE);
  assign tk.pdown   = (state_q == PMC_PDOWN);
  assign tk.rst_pin = ext_rst_pin;
  assign tk.hw_rst  = wdt_fire || power_fail;
  assign sys_rst    = tk.sys_rst;

  // ====
  // decode
  assign wr_power_control_reg  = reg_wr && hit(reg_addr, `PMC_ADDR_POWER_CONTROL_REG);
  assign wr_pmr   = reg_wr && hit(reg_addr, `PMC_ADDR_PMR);
  assign wr_wdt   = reg_wr && hit(reg_addr, `PMC_ADDR_WDT);
  assign wr_stat  = reg_wr && hit(reg_addr, `PMC_ADDR_STAT);
  assign restart  = wr_wdt && reg_wdata[`PMC_WDT_RESTART];
  assign idle_req = idle_q || (wr_power_control_reg && reg_wdata[`PMC_POWER_CONTROL_REG_IDLE]);
  assign pd_req   = pd_q || (wr_power_control_reg && reg_wdata[`PMC_POWER_CONTROL_REG_PD]);

  // flags of the serial unit are deliberately not inputs here
  assign sb_evt = swb_q && ((ser_rx_enable && rx_prev_q && !ser_rx_pin)
                  || ser_tx_write || ext_irq_ack);

  assign wake_idle = irq_pending || wdto_q;
  assign wake_pd   = global_irq_enable && |(ext_int_en & ~ext_int_b);

  // ====
  // power state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PMC_RUN:
      begin
        if (instr_done && pd_req)
          state_d = PMC_PDOWN;
        else if (instr_done && idle_req)
          state_d = PMC_IDLE;
      end
      PMC_IDLE:
      begin
        if (wake_idle)
          state_d = PMC_RUN;
      end
      PMC_PDOWN:
      begin
        if (wake_pd)
          state_d = PMC_RUN;
      end
      default:
        state_d = PMC_RUN;
    endcase
  end

  // reset exits any mode straight to run at address zero
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= PMC_RUN;
    else if (sys_rst)
      state_q <= PMC_RUN;
    else
      state_q <= state_d;
  end

  // ====
  // control register
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idle_q <= 1'b0;
      pd_q   <= 1'b0;
    end
    else if (sys_rst)
    begin
      idle_q <= 1'b0;
      pd_q   <= 1'b0;
    end
    else if (wr_power_control_reg)
    begin
      idle_q <= reg_wdata[`PMC_POWER_CONTROL_REG_IDLE];
      pd_q   <= reg_wdata[`PMC_POWER_CONTROL_REG_PD];
    end
    else
    begin
      if (state_q == PMC_IDLE && wake_idle)
        idle_q <= 1'b0;
      if (state_q == PMC_PDOWN && wake_pd)
        pd_q <= 1'b0;
    end
  end

  // ====
  // economy divider
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      swb_q <= 1'b0;
    else if (sys_rst)
      swb_q <= 1'b0;
    else if (wr_pmr)
      swb_q <= reg_wdata[`PMC_PMR_SWB];
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_q      <= `PMC_DIV_FAST;
      pend_div_q <= `PMC_DIV_FAST;
      pend_q     <= 1'b0;
      settle_q   <= 2'h0;
    end
    else if (sys_rst)
    begin
      div_q  <= `PMC_DIV_FAST;
      pend_q <= 1'b0;
    end
    else if (sb_evt)
    begin
      div_q  <= `PMC_DIV_FAST;
      pend_q <= 1'b0;
    end
    else if (wr_pmr && !(swb_q && ser_busy)
             && reg_wdata[`PMC_PMR_CD_HI:`PMC_PMR_CD_LO] != `PMC_DIV_RSVD)
    begin
      pend_div_q <= reg_wdata[`PMC_PMR_CD_HI:`PMC_PMR_CD_LO];
      pend_q     <= 1'b1;
      settle_q   <= `PMC_DIV_SETTLE;
    end
    else if (pend_q && tk.core_tick)
    begin
      settle_q <= settle_q - 2'h1;
      if (settle_q == 2'h1)
      begin
        div_q  <= pend_div_q;
        pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rx_prev_q <= 1'b1;
    else
      rx_prev_q <= ser_rx_pin;
  end

  // ====
  // watchdog
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_en_q <= 1'b0;
    else if (wr_wdt)
      rst_en_q <= reg_wdata[`PMC_WDT_RSTEN];
  end

  // counts peripheral ticks, which stop in power-down
  assign wdt_expire = tk.periph_tick && wdt_cnt_q == 17'(WDT_PERIOD - 1);
  assign wdt_fire   = armed_q && !tk.pdown && rcnt_q == 10'h001;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wdt_cnt_q <= 17'h00000;
      armed_q   <= 1'b0;
      rcnt_q    <= 10'h000;
    end
    else if (sys_rst || restart)
    begin
      wdt_cnt_q <= 17'h00000;
      armed_q   <= 1'b0;
    end
    else
    begin
      if (wdt_expire)
        wdt_cnt_q <= 17'h00000;
      else if (tk.periph_tick)
        wdt_cnt_q <= wdt_cnt_q + 17'h00001;
      if (wdt_expire && rst_en_q && !armed_q)
      begin
        armed_q <= 1'b1;
        rcnt_q  <= `PMC_WDT_RST_CLKS;
      end
      else if (armed_q && !tk.pdown)
      begin
        rcnt_q <= rcnt_q - 10'h001;
        if (rcnt_q == 10'h001)
          armed_q <= 1'b0;
      end
    end
  end

  // ====
  // status flags, a hardware set beats a software clear
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      wdto_q <= 1'b0;
    else if (wdt_expire)
      wdto_q <= 1'b1;
    else if (restart || (wr_stat && reg_wdata[`PMC_STAT_WDTO]) || sys_rst)
      wdto_q <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      por_q   <= 1'b1;
      wdrst_q <= 1'b0;
    end
    else
    begin
      if (power_fail)
        por_q <= 1'b1;
      else if (wr_stat && reg_wdata[`PMC_STAT_POR])
        por_q <= 1'b0;
      if (wdt_fire)
        wdrst_q <= 1'b1;
      else if (wr_stat && reg_wdata[`PMC_STAT_WDRST])
        wdrst_q <= 1'b0;
    end
  end

  // ====
  // read port
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `PMC_ADDR_POWER_CONTROL_REG: reg_rdata <= {6'h00, pd_q, idle_q};
        `PMC_ADDR_PMR:  reg_rdata <= {div_q, swb_q, 5'h00};
        `PMC_ADDR_WDT:  reg_rdata <= {7'h00, rst_en_q};
        `PMC_ADDR_STAT: reg_rdata <= {2'h0, state_q, wdto_q, wdrst_q, por_q};
        default:        reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ====
  // pins, following the state that reset really leaves
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ale_q  <= 1'b1;
      program_fetch_strobe_q <= 1'b1;
      hold_q <= 1'b0;
      regs_q <= 1'b0;
    end
    else
    begin
      case (sys_rst ? PMC_RUN : state_d)
        PMC_IDLE:
        begin
          ale_q  <= 1'b1;
          program_fetch_strobe_q <= 1'b1;
          hold_q <= 1'b1;
          regs_q <= 1'b0;
        end
        PMC_PDOWN:
        begin
          ale_q  <= 1'b0;
          program_fetch_strobe_q <= 1'b0;
          hold_q <= 1'b0;
          regs_q <= 1'b1;
        end
        default:
        begin
          ale_q  <= ale_core;
          program_fetch_strobe_q <= program_fetch_strobe_core;
          hold_q <= 1'b0;
          regs_q <= 1'b0;
        end
      endcase
    end
  end

  assign addr_latch_strobe    = ale_q;
  assign program_fetch_strobe = program_fetch_strobe_q;
  assign port_hold            = hold_q;
  assign port_from_regs       = regs_q;

  // core frozen whenever not running; reset flushes so nothing after idle executes
  assign cpu_cycle_en = (state_q == PMC_RUN) && tk.core_tick;
  assign core_reset   = sys_rst;
  assign osc_run      = (state_q != PMC_PDOWN);
  assign periph_tick  = tk.periph_tick;
  assign wdt_irq      = wdto_q;
endmodule : pmc_power_mode_clock_manager
`default_nettype wire

/* pmc_regs.svh */
// register offsets, field positions, reset values and timing counts of the power mode clock manager
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
// ====
// register offsets
`define PMC_ADDR_POWER_CONTROL_REG    8'h00
`define PMC_ADDR_PMR     8'h01
`define PMC_ADDR_WDT     8'h02
`define PMC_ADDR_STAT    8'h03
// ====
// field positions
`define PMC_POWER_CONTROL_REG_IDLE    0
`define PMC_POWER_CONTROL_REG_PD      1
`define PMC_PMR_CD_HI    7
`define PMC_PMR_CD_LO    6
`define PMC_PMR_SWB      5
`define PMC_WDT_RSTEN    0
`define PMC_WDT_RESTART  1
`define PMC_STAT_POR     0
`define PMC_STAT_WDRST   1
`define PMC_STAT_WDTO    2
// ====
// reset values
`define PMC_POWER_CONTROL_REG_RESET   8'h00
`define PMC_PMR_RESET    8'h40
`define PMC_DIV_RSVD     2'h0
`define PMC_DIV_FAST     2'h1
`define PMC_DIV_SLOW     2'h2
`define PMC_DIV_SLOWEST  2'h3
// ====
// timing counts, in clocks or machine cycles
`define PMC_CLKS_DIV4    11'h004
`define PMC_CLKS_DIV64   11'h040
`define PMC_CLKS_DIV1024 11'h400
`define PMC_RST_MIN_MC   2'h2
`define PMC_RST_HOLD_MC  2'h2
`define PMC_DIV_SETTLE   2'h2
`define PMC_WDT_RST_CLKS 10'h200
`endif

/* pmc_reset_seq.sv */
// reset sequencer: qualifies the reset pin and stretches every reset
`timescale 1ns/10ps
`default_nettype none
`include "pmc_regs.svh"
module pmc_reset_seq
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // tick carrier
  pmc_tick_if.seq  tk
);
  logic [1:0] seen_q;
  logic [1:0] hold_q;
  logic       rst_q;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seen_q <= 2'h0;
      hold_q <= `PMC_RST_HOLD_MC;
      rst_q  <= 1'b1;
    end
    else if (tk.hw_rst || (tk.pdown && tk.rst_pin))
    begin
      rst_q  <= 1'b1;
      hold_q <= `PMC_RST_HOLD_MC;
    end
    else if (tk.core_tick)
    begin
      // pin sampled once per machine cycle, last clock of the cycle
      if (tk.rst_pin)
      begin
        seen_q <= (seen_q == `PMC_RST_MIN_MC) ? seen_q : seen_q + 2'h1;
        if (seen_q + 2'h1 >= `PMC_RST_MIN_MC)
        begin
          rst_q  <= 1'b1;
          hold_q <= `PMC_RST_HOLD_MC;
        end
      end
      else
      begin
        seen_q <= 2'h0;
        if (rst_q)
        begin
          hold_q <= hold_q - 2'h1;
          if (hold_q == 2'h1)
            rst_q <= 1'b0;
        end
      end
    end
  end

  assign tk.sys_rst = rst_q;
endmodule : pmc_reset_seq
`default_nettype wire

/* pmc_tick_if.sv */
// interface carrying divider, tick and reset signals between the manager and its leaves
`timescale 1ns/10ps
`default_nettype none
interface pmc_tick_if;
  logic [1:0] div_sel;
  logic       idle;
  logic       pdown;
  logic       core_tick;
  logic       periph_tick;
  logic       rst_pin;
  logic       hw_rst;
  logic       sys_rst;
  modport gen (input div_sel, input idle, input pdown, output core_tick, output periph_tick);
  modport seq (input core_tick, input pdown, input rst_pin, input hw_rst, output sys_rst);
  modport ctl (output div_sel, output idle, output pdown, output rst_pin, output hw_rst,
               input core_tick, input periph_tick, input sys_rst);
endinterface : pmc_tick_if
`default_nettype wire

/* testbench.sv */
// self-checking bench of the power mode clock manager
`timescale 1ns/10ps
`default_nettype none
`include "pmc_regs.svh"
module testbench;
  import pmc_pkg::*;
  logic      sys_clk, rst_b, reg_wr, reg_rd, instr_done, ale_core, program_fetch_strobe_core;
  logic      cpu_cycle_en, core_reset, addr_latch_strobe, program_fetch_strobe, port_hold;
  logic      port_from_regs, osc_run, periph_tick, irq_pending, global_irq_enable, ext_irq_ack;
  logic      wdt_irq, ser_rx_pin, ser_rx_enable, ser_tx_write, ser_busy, ext_rst_pin, power_fail;
  logic [1:0] ext_int_b, ext_int_en;
  pmc_byte_t reg_addr, reg_wdata, reg_rdata, d;
  int        failures, checks, n, m;
  logic [31:0] k;
  pmc_power_mode_clock_manager #(.WDT_PERIOD(64)) i_dut
  (
    .sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .instr_done, .ale_core,
    .program_fetch_strobe_core, .cpu_cycle_en, .core_reset, .addr_latch_strobe, .program_fetch_strobe,
    .port_hold, .port_from_regs, .osc_run, .periph_tick, .irq_pending, .ext_int_b, .ext_int_en,
    .global_irq_enable, .ext_irq_ack, .wdt_irq, .ser_rx_pin, .ser_rx_enable, .ser_tx_write, .ser_busy,
    .ext_rst_pin, .power_fail
  );
  pmc_core_model i_core
  (
    .sys_clk, .rst_b, .cpu_cycle_en, .core_reset, .instr_done, .ale_core, .program_fetch_strobe_core
  );
  // ====
  // helpers
  task end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  function logic cond(input int sel);
    case (sel)
      0: return port_hold;
      1: return port_from_regs;
      2: return !port_from_regs;
      3: return core_reset;
      4: return !core_reset;
      5: return cpu_cycle_en;
      6: return periph_tick;
      7: return wdt_irq;
      default: return !port_hold;
    endcase
  endfunction : cond
  task wait_for(input int sel, input int bound, output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (cond(sel) !== 1'b1 && n < bound);
    if (cond(sel) !== 1'b1)
    begin
      failures++;
      $display("FAIL wait %0d expected 1 seen 0", sel);
      end_of_test();
    end
  endtask : wait_for
  task per(input int sel, input int reps, output int n);
    repeat (reps) wait_for(sel, 2100, n);
  endtask : per
  task count(input int sel, input int k, output int n);
    n = 0;
    repeat (k)
    begin
      @(posedge sys_clk);
      #1;
      if (cond(sel) === 1'b1)
        n++;
    end
  endtask : count
  task wr(input pmc_byte_t a, input pmc_byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input pmc_byte_t a, output pmc_byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task pulse(input int sel, input int k);
    @(posedge sys_clk);
    case (sel)
      0: ser_tx_write <= 1'b1;
      1: ext_irq_ack <= 1'b1;
      2, 3: ser_rx_pin <= 1'b0;
      4: irq_pending <= 1'b1;
      default: ext_rst_pin <= 1'b1;
    endcase
    repeat (k) @(posedge sys_clk);
    {ser_tx_write, ext_irq_ack, irq_pending, ext_rst_pin} <= 4'h0;
    ser_rx_pin <= 1'b1;
  endtask : pulse
  // ====
  // scenarios
  task t_reset();
    wait_for(4, 40, n);
    rd(`PMC_ADDR_PMR, d);
    chk("pmr_reset", d, `PMC_PMR_RESET);
    rd(`PMC_ADDR_POWER_CONTROL_REG, d);
    chk("power_control_reg_reset", d, `PMC_POWER_CONTROL_REG_RESET);
    rd(`PMC_ADDR_STAT, d);
    chk("por_flag", d & 8'h3B, 8'h09);
    wr(`PMC_ADDR_STAT, 8'h01);
    rd(`PMC_ADDR_STAT, d);
    chk("por_clear", d & 8'h3B, 8'h08);
    rd(8'h7F, d);
    chk("unmapped", d, 8'h00);
    per(5, 2, n);
    chk("div4", n, 4);
  endtask : t_reset
  task t_divide();
    wr(`PMC_ADDR_PMR, 8'h80);
    count(5, 8, n);
    chk("div_delay", n, 2);
    per(5, 2, n);
    chk("div64", n, 64);
    per(6, 2, n);
    chk("periph64", n, 64);
    wr(`PMC_ADDR_PMR, 8'h40);
    per(5, 3, n);
    chk("div4_back", n, 4);
    wr(`PMC_ADDR_PMR, 8'hC0);
    per(5, 3, n);
    chk("div1024", n, 1024);
    wr(`PMC_ADDR_PMR, 8'h00);
    rd(`PMC_ADDR_PMR, d);
    chk("div_rsvd", d, 8'hC0);
    wr(`PMC_ADDR_PMR, 8'h40);
    per(5, 3, n);
    chk("div4_again", n, 4);
  endtask : t_divide
  task t_switchback();
    for (int i = 0; i < 4; i++)
    begin
      wr(`PMC_ADDR_PMR, 8'hA0);
      per(5, 3, n);
      ser_rx_enable <= (i == 2);
      pulse(i, 2);
      rd(`PMC_ADDR_PMR, d);
      chk("swb_div", d, (i < 3) ? 8'h60 : 8'hA0);
      per(5, 2, n);
      chk("swb_rate", n, (i < 3) ? 4 : 64);
    end
    ser_busy <= 1'b1;
    wr(`PMC_ADDR_PMR, 8'h60);
    rd(`PMC_ADDR_PMR, d);
    chk("busy_drop", d, 8'hA0);
    ser_busy <= 1'b0;
    wr(`PMC_ADDR_PMR, 8'h40);
    per(5, 3, n);
  endtask : t_switchback
  task t_idle();
    wr(`PMC_ADDR_STAT, 8'h04);
    wr(`PMC_ADDR_WDT, 8'h02);
    wr(`PMC_ADDR_PMR, 8'h80);
    wr(`PMC_ADDR_POWER_CONTROL_REG, 8'h01);
    wait_for(0, 2100, n);
    k = i_core.instr_cnt_q;
    count(6, 40, n);
    chk("idle_periph", n, 10);
    chk("idle_halt", i_core.instr_cnt_q, k);
    chk("idle_strobes", {addr_latch_strobe, program_fetch_strobe}, 2'h3);
    pulse(4, 1);
    #1;
    chk("idle_exit", port_hold, 1'b0);
    rd(`PMC_ADDR_POWER_CONTROL_REG, d);
    chk("idle_clear", d, 8'h00);
    wr(`PMC_ADDR_PMR, 8'h40);
    per(5, 3, n);
  endtask : t_idle
  task t_rst_pin();
    wr(`PMC_ADDR_STAT, 8'h04);
    wr(`PMC_ADDR_WDT, 8'h02);
    wr(`PMC_ADDR_POWER_CONTROL_REG, 8'h01);
    wait_for(0, 2100, n);
    k = i_core.instr_cnt_q;
    pulse(5, 3);
    count(3, 12, n);
    chk("short_pin", n, 0);
    pulse(5, 8);
    wait_for(3, 8, n);
    chk("no_fetch", i_core.instr_cnt_q, k);
    wait_for(4, 40, n);
    rd(`PMC_ADDR_STAT, d);
    chk("pin_rst_run", d & 8'h3B, 8'h08);
  endtask : t_rst_pin
  task t_pd();
    wr(`PMC_ADDR_POWER_CONTROL_REG, 8'h02);
    wait_for(1, 40, n);
    chk("pd_pins", {addr_latch_strobe, program_fetch_strobe, osc_run}, 3'h0);
    ext_int_b <= 2'h2;
    count(2, 10, n);
    chk("pd_masked", n, 0);
    ext_int_en <= 2'h1;
    count(2, 10, n);
    chk("pd_no_global", n, 0);
    global_irq_enable <= 1'b1;
    wait_for(2, 8, n);
    rd(`PMC_ADDR_POWER_CONTROL_REG, d);
    chk("pd_clear", d, 8'h00);
    ext_int_b <= 2'h3;
    global_irq_enable <= 1'b0;
  endtask : t_pd
  task t_pd_rst();
    wr(`PMC_ADDR_PMR, 8'h80);
    wr(`PMC_ADDR_POWER_CONTROL_REG, 8'h02);
    wait_for(1, 2100, n);
    pulse(5, 4);
    wait_for(4, 40, n);
    chk("pd_rst_exit", {port_from_regs, osc_run}, 2'h1);
    rd(`PMC_ADDR_PMR, d);
    chk("pd_rst_div", d, 8'h40);
    per(5, 2, n);
    chk("pd_rst_rate", n, 4);
  endtask : t_pd_rst
  task t_wdt();
    wr(`PMC_ADDR_PMR, 8'h80);
    wr(`PMC_ADDR_STAT, 8'h04);
    wr(`PMC_ADDR_WDT, 8'h03);
    wr(`PMC_ADDR_POWER_CONTROL_REG, 8'h01);
    wait_for(0, 2100, n);
    wait_for(7, 2100, n);
    wait_for(8, 3, m);
    chk("wdt_wake", port_hold, 1'b0);
    wait_for(3, 600, n);
    chk("wdt_delay", (n + m) inside {[511:513]}, 1'b1);
    wait_for(4, 40, n);
    rd(`PMC_ADDR_STAT, d);
    chk("wdrst_flag", d[1], 1'b1);
    rd(`PMC_ADDR_PMR, d);
    chk("wdrst_div", d, 8'h40);
  endtask : t_wdt
  // ====
  // clock and main sequence
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial
  begin
    failures = 0;
    checks = 0;
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ext_int_b = 2'h3;
    ext_int_en = 2'h0;
    ser_rx_pin = 1'b1;
    {reg_wr, reg_rd, irq_pending, global_irq_enable, ext_irq_ack} = 5'h0;
    {ser_rx_enable, ser_tx_write, ser_busy, ext_rst_pin, power_fail} = 5'h0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_divide();
    t_switchback();
    t_idle();
    t_rst_pin();
    t_pd();
    t_pd_rst();
    t_wdt();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
